// ===== verilog/bit_band_consts.vh
// Constants for the bit-band alias remapper: alias tags, field positions,
// access size codes and state-independent reset values.
// Assumes a 32-bit byte address bus with little-endian byte lanes.
`ifndef BIT_BAND_CONSTS_VH
`define BIT_BAND_CONSTS_VH

// Address bits 31:25 that mark each 32 MB alias window
`define BB_TAG_MSB 31
`define BB_TAG_LSB 25
`define BB_SRAM_ALIAS_TAG 7'h11
`define BB_PERI_ALIAS_TAG 7'h21
// Start of each alias window
`define BB_SRAM_ALIAS_BASE 32'h2200_0000
`define BB_PERI_ALIAS_BASE 32'h4200_0000
// Alias address fields: byte offset in the 1 MB bit-band region and bit number
`define BB_BYTE_OFF_MSB 24
`define BB_BYTE_OFF_LSB 5
`define BB_BIT_NUM_MSB 4
`define BB_BIT_NUM_LSB 2
// Region nibble (address bits 31:28) kept in the bit-band target address
`define BB_REGION_MSB 31
`define BB_REGION_LSB 28
`define BB_TARGET_GAP 8'h00
// Access size codes
`define BB_SIZE_BYTE 2'h0
`define BB_SIZE_HALF 2'h1
`define BB_SIZE_WORD 2'h2
// Alias read answers
`define BB_READ_CLEAR 32'h0000_0000
`define BB_READ_SET 32'h0000_0001
// Reset values
`define BB_RST_ADDR 32'h0000_0000
`define BB_RST_DATA 32'h0000_0000

`endif

// ===== verilog/bit_band_alias_decode.v
// Alias address decoder: tells whether an address falls in an alias window
// and, if so, forms the bit-band byte address and the bit number.
// Purely combinational; the caller registers whatever it needs.
`include "bit_band_consts.vh"
`default_nettype none

module bit_band_alias_decode (
  input wire [31:0] addr,        // Address of the incoming access
  output wire is_alias,          // Address lies in either alias window
  output wire is_peri,           // Alias hit is in the peripheral window
  output wire [31:0] target_addr, // Bit-band byte holding the target bit
  output wire [2:0] bit_num      // Bit position 0-7 inside that byte
);

  wire [6:0] tag;
  wire sram_hit;
  wire peri_hit;

  assign tag = addr[`BB_TAG_MSB:`BB_TAG_LSB];
  assign sram_hit = (tag == `BB_SRAM_ALIAS_TAG);
  assign peri_hit = (tag == `BB_PERI_ALIAS_TAG);
  assign is_alias = sram_hit | peri_hit;
  assign is_peri = peri_hit;
  // offset is byte*32 + bit*4, so the fields fall out of the address
  // offset is relative to the window base
  assign target_addr = {addr[`BB_REGION_MSB:`BB_REGION_LSB], `BB_TARGET_GAP,
                        addr[`BB_BYTE_OFF_MSB:`BB_BYTE_OFF_LSB]};
  assign bit_num = addr[`BB_BIT_NUM_MSB:`BB_BIT_NUM_LSB];

endmodule

`default_nettype wire

// ===== verilog/bit_band_alias_remapper.v
// Bit-band alias remapper between the core data bus and SRAM/peripheral memory.
// Assumes one outstanding access; memory answers each held request with a
// one-cycle ack and returns read data on little-endian byte lanes.
// Limitation: one access in flight; the core waits on ready between accesses.
// Reserved size code 3 is forwarded as it stands; memory decides what it means.
//
// Functional notes
// - Lowest 1 MB of SRAM, peripheral are bit-band
// - SRAM alias word maps to one bit
// - Peripheral alias word maps to one bit
// - Underlying access keeps original access size
// - SRAM bit-band direct accesses pass unchanged
// - SRAM alias: remap data, RMW writes, fetch passes
// - Peripheral bit-band direct accesses pass unchanged
// - Peripheral alias: remap data, RMW, refuse fetch
// - Offset equals byte times 32 plus bit times 4
// - Alias address is window base plus offset
// - Decode bit position 0-7 within byte
// - Write bit 0 sets or clears target
// - Written bits 31:1 are ignored
// - Alias read returns 0 or 1
// - Bytes numbered upward, four per word
// - Words stored little-endian
`include "bit_band_consts.vh"
`default_nettype none

module bit_band_alias_remapper (
  input wire clk_sys,           // System clock, 50 MHz
  input wire rst_b,             // Synchronous reset, active low
  input wire req_valid,         // Core presents an access
  output reg req_ready_q,       // Block can take an access
  input wire [31:0] req_addr,   // Core byte address
  input wire req_write,         // 1 store, 0 load
  input wire [1:0] req_size,    // 0 byte, 1 halfword, 2 word
  input wire [31:0] req_wdata,  // Store data on byte lanes
  input wire req_fetch,         // Access is an instruction fetch
  output reg rsp_valid_q,       // Answer to the core, one cycle
  output reg [31:0] rsp_rdata_q, // Load data for the core
  output reg rsp_err_q,         // Access refused
  output reg mem_req_q,         // Request to memory, held until ack
  output reg [31:0] mem_addr_q, // Memory byte address
  output reg mem_write_q,       // Memory write
  output reg [1:0] mem_size_q,  // Memory access size
  output reg [31:0] mem_wdata_q, // Memory write data
  output reg mem_lock_q,        // Keeps the read-modify-write pair together
  output reg mem_fetch_q,       // Memory access is an instruction fetch
  input wire mem_ack,           // Memory completes current request
  input wire [31:0] mem_rdata   // Memory read data, valid with ack
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_PASS = 3'd1;
  localparam [2:0] ST_ARD = 3'd2;
  localparam [2:0] ST_AWR = 3'd3;
  localparam [2:0] ST_RESP = 3'd4;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [4:0] lane_bit_q;
  reg [4:0] lane_bit_d;
  reg set_val_q;
  reg set_val_d;
  reg alias_wr_q;
  reg alias_wr_d;
  reg req_ready_d;
  reg rsp_valid_d;
  reg [31:0] rsp_rdata_d;
  reg rsp_err_d;
  reg mem_req_d;
  reg [31:0] mem_addr_d;
  reg mem_write_d;
  reg [1:0] mem_size_d;
  reg [31:0] mem_wdata_d;
  reg mem_lock_d;
  reg mem_fetch_d;

  wire dec_alias;
  wire dec_peri;
  wire [31:0] dec_target;
  wire [2:0] dec_bit;
  wire take;
  wire fetch_refused;
  wire alias_data;

  bit_band_alias_decode u_decode (
    .addr(req_addr),
    .is_alias(dec_alias),
    .is_peri(dec_peri),
    .target_addr(dec_target),
    .bit_num(dec_bit)
  );

  // Aligns a byte address down to the natural boundary of the access size
  function [31:0] align_addr;
    input [31:0] a;
    input [1:0] sz;
    begin
      case (sz)
        `BB_SIZE_HALF: align_addr = {a[31:1], 1'b0};
        `BB_SIZE_WORD: align_addr = {a[31:2], 2'b00};
        default: align_addr = a;
      endcase
    end
  endfunction

  // Bit index within the 32-bit lane word: byte lane above, bit number below
  function [4:0] lane_bit;
    input [31:0] byte_addr;
    input [2:0] bnum;
    begin
      lane_bit = {byte_addr[1:0], bnum};
    end
  endfunction

  assign take = req_valid & req_ready_q;
  assign fetch_refused = dec_alias & dec_peri & req_fetch;
  assign alias_data = dec_alias & ~req_fetch;

  // Replaces one bit of the lane word read back; the other 31 bits go back
  // untouched, which keeps neighbouring flags in the same word safe
  function [31:0] put_bit;
    input [31:0] word;
    input [4:0] idx;
    input val;
    begin
      put_bit = word;
      put_bit[idx] = val;
    end
  endfunction

  // Alias reads answer a whole word of 0 or 1, whatever the access size
  function [31:0] bit_answer;
    input [31:0] word;
    input [4:0] idx;
    begin
      if (word[idx]) begin
        bit_answer = `BB_READ_SET;
      end else begin
        bit_answer = `BB_READ_CLEAR;
      end
    end
  endfunction

  // Next-state and output logic; every output except rsp_valid_q and rsp_err_q holds unless a state moves it
  always @* begin
    state_d = state_q;
    lane_bit_d = lane_bit_q;
    set_val_d = set_val_q;
    alias_wr_d = alias_wr_q;
    req_ready_d = req_ready_q;
    rsp_valid_d = 1'b0;
    rsp_rdata_d = rsp_rdata_q;
    rsp_err_d = 1'b0;
    mem_req_d = mem_req_q;
    mem_addr_d = mem_addr_q;
    mem_write_d = mem_write_q;
    mem_size_d = mem_size_q;
    mem_wdata_d = mem_wdata_q;
    mem_lock_d = mem_lock_q;
    mem_fetch_d = mem_fetch_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          req_ready_d = 1'b0;
          if (fetch_refused) begin
            // peripheral alias fetch refused
            // No memory cycle at all: the refused fetch never reaches the bus
            rsp_valid_d = 1'b1;
            rsp_err_d = 1'b1;
            rsp_rdata_d = `BB_RST_DATA;
            state_d = ST_RESP;
          end else if (alias_data) begin
            mem_req_d = 1'b1;
            // Aligned so a halfword or word never straddles its boundary
            mem_addr_d = align_addr(dec_target, req_size);
            mem_size_d = req_size;
            mem_write_d = 1'b0;
            mem_fetch_d = 1'b0;
            mem_lock_d = req_write;
            lane_bit_d = lane_bit(dec_target, dec_bit);
            set_val_d = req_wdata[0];
            alias_wr_d = req_write;
            state_d = ST_ARD;
          end else begin
            mem_req_d = 1'b1;
            mem_addr_d = req_addr;
            mem_size_d = req_size;
            mem_write_d = req_write;
            mem_wdata_d = req_wdata;
            mem_fetch_d = req_fetch;
            mem_lock_d = 1'b0;
            state_d = ST_PASS;
          end
        end
      end
      // Plain forward: the answer carries whatever memory returned
      ST_PASS: begin
        if (mem_ack) begin
          mem_req_d = 1'b0;
          rsp_valid_d = 1'b1;
          rsp_rdata_d = mem_rdata;
          state_d = ST_RESP;
        end
      end
      ST_ARD: begin
        if (mem_ack) begin
          if (alias_wr_q) begin
            mem_wdata_d = put_bit(mem_rdata, lane_bit_q, set_val_q);
            // Request stays up between read and write so nothing slips in
            mem_write_d = 1'b1;
            state_d = ST_AWR;
          end else begin
            mem_req_d = 1'b0;
            mem_lock_d = 1'b0;
            rsp_valid_d = 1'b1;
            rsp_rdata_d = bit_answer(mem_rdata, lane_bit_q);
            state_d = ST_RESP;
          end
        end
      end
      ST_AWR: begin
        if (mem_ack) begin
          mem_req_d = 1'b0;
          mem_write_d = 1'b0;
          mem_lock_d = 1'b0;
          rsp_valid_d = 1'b1;
          rsp_rdata_d = `BB_RST_DATA;
          state_d = ST_RESP;
        end
      end
      ST_RESP: begin
        // One idle cycle lets the core see the answer before the next access
        req_ready_d = 1'b1;
        state_d = ST_IDLE;
      end
      // Unused codes fall back to idle with the memory request dropped
      default: begin
        mem_req_d = 1'b0;
        mem_lock_d = 1'b0;
        req_ready_d = 1'b1;
        state_d = ST_IDLE;
      end
    endcase
  end

  // One flat register stage keeps every output straight from a flip-flop
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      lane_bit_q <= 5'h00;
      set_val_q <= 1'b0;
      alias_wr_q <= 1'b0;
      req_ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= `BB_RST_DATA;
      rsp_err_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_addr_q <= `BB_RST_ADDR;
      mem_write_q <= 1'b0;
      mem_size_q <= `BB_SIZE_BYTE;
      mem_wdata_q <= `BB_RST_DATA;
      mem_lock_q <= 1'b0;
      mem_fetch_q <= 1'b0;
    end else begin
      state_q <= state_d;
      lane_bit_q <= lane_bit_d;
      set_val_q <= set_val_d;
      alias_wr_q <= alias_wr_d;
      req_ready_q <= req_ready_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_rdata_q <= rsp_rdata_d;
      rsp_err_q <= rsp_err_d;
      mem_req_q <= mem_req_d;
      mem_addr_q <= mem_addr_d;
      mem_write_q <= mem_write_d;
      mem_size_q <= mem_size_d;
      mem_wdata_q <= mem_wdata_d;
      mem_lock_q <= mem_lock_d;
      mem_fetch_q <= mem_fetch_d;
    end
  end

endmodule

`default_nettype wire

// ===== verif/bb_mem_model.sv
// Memory behind the remapper: 16 words, little-endian byte lanes.
// Acks alternate between fast and slow; read lines toggle when idle.
`default_nettype none
module bb_mem_model (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic mem_req_q, // Request held until ack
  input wire logic mem_write_q, // Write request
  input wire logic [1:0] mem_size_q, // Access size
  input wire logic [31:0] mem_addr_q, // Byte address
  input wire logic [31:0] mem_wdata_q, // Write data on byte lanes
  output logic mem_ack, // Completion
  output logic [31:0] mem_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] ram [0:15];
  logic [31:0] m;
  logic [3:0] ix;
  logic [1:0] w;
  logic slow;
  assign ix = {mem_addr_q[30], mem_addr_q[4:2]};
  assign m = mem_size_q == 2'h2 ? 32'hFFFF_FFFF : mem_size_q == 2'h1 ?
    32'h0000_FFFF << {mem_addr_q[1], 4'h0} : 32'h0000_00FF << {mem_addr_q[1:0], 3'h0};
  always @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rst_b) begin
      w <= 2'h0;
      slow <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      for (int i = 0; i < 16; i++) ram[i] <= 32'h0000_0000;
    end else if (mem_req_q && !mem_ack) begin
      w <= w + 2'h1;
      if (w == {slow, 1'b0}) begin
        w <= 2'h0;
        slow <= !slow;
        mem_ack <= 1'b1;
        mem_rdata <= ram[ix];
        if (mem_write_q) ram[ix] <= (ram[ix] & ~m) | (mem_wdata_q & m);
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/bb_chk_assertions.sv
// Port checker for the bit-band remapper.
// Assumes one access in flight, as the remapper's contract gives.
`default_nettype none
module bb_chk (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic req_valid, // Core access present
  input wire logic req_ready_q, // Block can take an access
  input wire logic req_write, // Core store
  input wire logic req_fetch, // Core fetch
  input wire logic [31:0] req_addr, // Core address
  input wire logic [31:0] req_wdata, // Core store data
  input wire logic [31:0] rsp_rdata_q, // Answer data
  input wire logic [31:0] mem_addr_q, // Memory address
  input wire logic [31:0] mem_wdata_q, // Memory write data
  input wire logic [31:0] mem_rdata, // Memory read data
  input wire logic [1:0] req_size, // Core size
  input wire logic [1:0] mem_size_q, // Memory size
  input wire logic rsp_valid_q, // Answer strobe
  input wire logic rsp_err_q, // Refusal
  input wire logic mem_req_q, // Memory request
  input wire logic mem_write_q, // Memory write
  input wire logic mem_lock_q, // Read-modify-write lock
  input wire logic mem_fetch_q, // Forwarded fetch flag
  input wire logic mem_ack // Memory completion
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic tk, ph, ah, rd_q, wb_q;
  logic [4:0] bs_q;
  assign tk = req_valid && req_ready_q;
  assign ph = req_addr[31:25] == 7'h21;
  assign ah = !req_fetch && (ph || req_addr[31:25] == 7'h11);
  // Bit index in the word is byte lane then bit number
  always @(posedge clk_sys) begin
    if (!rst_b) rd_q <= 1'b0;
    else if (tk) rd_q <= ah && !req_write;
    if (tk) bs_q <= req_addr[6:2];
    if (tk) wb_q <= req_wdata[0];
  end
  chk_fetch_refused: assert property (tk && req_fetch && ph |=> rsp_valid_q && rsp_err_q
    && !mem_req_q && rsp_rdata_q == 32'h0000_0000) else $error("fetch not refused");
  chk_pass_addr: assert property (tk && !ah && !(req_fetch && ph) |=> mem_req_q
    && mem_addr_q == $past(req_addr) && mem_fetch_q == $past(req_fetch)
    && mem_write_q == $past(req_write) && mem_wdata_q == $past(req_wdata))
    else $error("pass addr");
  chk_alias_addr: assert property (tk && ah |=> !mem_write_q && mem_addr_q[31:2] ==
    {$past(req_addr[31:28]), 8'h00, $past(req_addr[24:7])}) else $error("alias addr");
  chk_size_kept: assert property (tk && !(req_fetch && ph) |=>
    mem_size_q == $past(req_size)) else $error("size changed");
  chk_alias_read: assert property (mem_ack && rd_q |=> rsp_valid_q &&
    rsp_rdata_q == {31'h0, $past(mem_rdata[bs_q])}) else $error("alias read value");
  chk_rmw_write: assert property (mem_ack && mem_lock_q && !mem_write_q |=>
    mem_req_q && mem_write_q && mem_wdata_q == (($past(mem_rdata) & ~(32'h0000_0001 << bs_q))
    | ({31'h0, wb_q} << bs_q))) else $error("rmw write data");
  chk_lock_held: assert property (mem_lock_q |-> mem_req_q) else $error("lock idle");
  chk_req_stable: assert property (mem_req_q && !mem_ack |=> mem_req_q &&
    $stable(mem_addr_q) && $stable(mem_wdata_q) && $stable(mem_write_q)) else $error("req moved");
  chk_rmw_locked: assert property (tk && ah && req_write |=> mem_req_q && mem_lock_q
    && !mem_write_q) else $error("rmw read not locked");
  chk_lock_release: assert property (mem_ack && mem_lock_q && mem_write_q |=> !mem_lock_q
    && !mem_req_q && rsp_valid_q && !rsp_err_q) else $error("rmw lock not released");
  cover property (tk && ah && req_write);
  cover property (tk && req_fetch && ph);
  cover property (mem_ack && rd_q);
endmodule
bind bit_band_alias_remapper bb_chk u_chk (.clk_sys, .rst_b, .req_valid, .req_ready_q,
  .req_write, .req_fetch, .req_addr, .req_wdata, .rsp_rdata_q, .mem_addr_q, .mem_wdata_q,
  .mem_rdata, .req_size, .mem_size_q, .rsp_valid_q, .rsp_err_q, .mem_req_q, .mem_write_q,
  .mem_lock_q, .mem_fetch_q, .mem_ack);
`default_nettype wire

// ===== verif/tb.sv
// Bench for the bit-band remapper with a memory model behind it.
// Drives one core access at a time and waits for each answer.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_b, req_valid, req_write, req_fetch, mem_ack, er;
  logic req_ready_q, rsp_valid_q, rsp_err_q, mem_req_q, mem_write_q, mem_lock_q, mem_fetch_q;
  logic [1:0] req_size, mem_size_q;
  logic [31:0] req_addr, req_wdata, mem_rdata, rsp_rdata_q, mem_addr_q, mem_wdata_q, rd;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  bit_band_alias_remapper DUT (.clk_sys, .rst_b, .req_valid, .req_ready_q, .req_addr,
    .req_write, .req_size, .req_wdata, .req_fetch, .rsp_valid_q, .rsp_rdata_q, .rsp_err_q,
    .mem_req_q, .mem_addr_q, .mem_write_q, .mem_size_q, .mem_wdata_q, .mem_lock_q,
    .mem_fetch_q, .mem_ack, .mem_rdata);
  bb_mem_model mem (.clk_sys, .rst_b, .mem_req_q, .mem_write_q, .mem_size_q, .mem_addr_q,
    .mem_wdata_q, .mem_ack, .mem_rdata);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Taken at the first edge: ready is back high once the last answer is gone
  task automatic acc(input logic [31:0] a, d, input logic [1:0] s, input logic w, f);
    int n;
    n = 0;
    req_addr <= a;
    req_wdata <= d;
    req_size <= s;
    req_write <= w;
    req_fetch <= f;
    req_valid <= 1'b1;
    @(posedge clk_sys);
    chk("ready at take", {31'h0, req_ready_q}, 32'h0000_0001);
    req_valid <= 1'b0;
    req_addr <= ~a;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp_valid_q !== 1'b1 && n < 20);
    rd = rsp_rdata_q;
    er = rsp_err_q;
    chk("answer", {31'h0, rsp_valid_q}, 32'h0000_0001);
    chk("ready in answer", {31'h0, req_ready_q}, 32'h0000_0000);
  endtask
  task automatic t_alias_sram;
    acc(32'h2200_001C, 32'h0000_00FF, 2'h2, 1'b1, 1'b0);
    acc(32'h2200_0020, 32'h0000_0001, 2'h2, 1'b1, 1'b0);
    acc(32'h2200_001C, 32'h0000_000E, 2'h2, 1'b1, 1'b0);
    acc(32'h2200_001C, 32'h0000_0000, 2'h2, 1'b0, 1'b0);
    chk("alias clear", rd, 32'h0000_0000);
    acc(32'h2200_0020, 32'h0000_0000, 2'h2, 1'b0, 1'b0);
    chk("alias set", rd, 32'h0000_0001);
    acc(32'h2000_0000, 32'h0000_0000, 2'h2, 1'b0, 1'b0);
    chk("sram word", rd, 32'h0000_0100);
    acc(32'h2200_0000, 32'h0000_0000, 2'h2, 1'b0, 1'b1);
    chk("sram fetch", {rd[30:0], er}, 32'h0000_0200);
  endtask
  task automatic t_alias_peri;
    acc(32'h4200_0074, 32'h0000_0001, 2'h1, 1'b1, 1'b0);
    acc(32'h4000_0000, 32'h0000_0000, 2'h2, 1'b0, 1'b0);
    chk("peri word", rd, 32'h2000_0000);
    acc(32'h4200_0074, 32'h0000_0000, 2'h0, 1'b0, 1'b0);
    chk("peri byte read", rd, 32'h0000_0001);
    acc(32'h4200_0074, 32'h0000_0000, 2'h2, 1'b0, 1'b1);
    chk("peri fetch", {rd[30:0], er}, 32'h0000_0001);
  endtask
  task automatic t_alias_top;
    acc(32'h23FF_FFFC, 32'h0000_0001, 2'h2, 1'b1, 1'b0);
    acc(32'h200F_FFFC, 32'h0000_0000, 2'h2, 1'b0, 1'b0);
    chk("top bit", rd, 32'h8000_0000);
    acc(32'h23FF_FFE0, 32'h0000_0000, 2'h2, 1'b0, 1'b0);
    chk("top bit0", rd, 32'h0000_0000);
  endtask
  task automatic t_direct;
    acc(32'h2000_0008, 32'h1234_5678, 2'h2, 1'b1, 1'b0);
    acc(32'h2000_000B, 32'hAB00_0000, 2'h0, 1'b1, 1'b0);
    acc(32'h2000_0008, 32'h0000_0000, 2'h2, 1'b0, 1'b0);
    chk("byte lane", rd, 32'hAB34_5678);
    acc(32'h4000_0004, 32'hCAFE_0001, 2'h2, 1'b1, 1'b0);
    acc(32'h4000_0004, 32'h0000_0000, 2'h2, 1'b0, 1'b0);
    chk("peri direct", rd, 32'hCAFE_0001);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_fetch = 1'b0;
    req_size = 2'h0;
    req_addr = 32'h0000_0000;
    req_wdata = 32'h0000_0000;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_alias_sram();
    t_alias_peri();
    t_alias_top();
    t_direct();
    end_of_test();
  end
endmodule
`default_nettype wire
